// ==== core/debug_port_lock.sv ====
/*
 * debug port selection, trace pairing, flash permission and lock latch.
 * assumes the nonvolatile cell array sits on clk and shows its word on
 * nvReadWord; the wire clocks come from the host and may stop.
 */
`default_nettype none
// Overview of operation
// - wire debug uses one host clock pin and one two-way data pin
// - wire debug offered on jtag mode/clock pins or usb d+/d- pins
// - wire debug enabled on at most one pin pair at a time
// - acquisition pattern enables a pair only within 8 us of reset
// - wire debug has debug functions but no scan chain access
// - jtag session may switch wire debug on; off returns pins to gpio
// - reacquire allowed in key window only while no pair is on; session may re-enable jtag
// - wire debug pairs with either trace; jtag only with parallel trace
// - parallel trace uses five pins, single trace one jtag pin
// - raised flash protection cleared only during full device erase
// - block erase/program/verify only if block security allows it
// - latch outputs one when at least 28 of 32 bits match key
// - lock blocks debug and test and freezes latch contents
// - latch output sampled only at reset to disable access
// - lock needs key loaded, committed to cells, then a reset
// - key write accepted only while no flash protection is set
// - access stays available after key write until next reset
// - latch contents readable over wire debug
// - six program-address and two literal breakpoint comparators
// - jtag enabled by default, may be disabled to gpio
module debug_port_lock #(
	parameter int NUM_PC_BKPT  = 6,
	parameter int NUM_LIT_BKPT = 2
) (
	// system
	input  wire logic                      clk,
	input  wire logic                      rst,
	// wire debug pins, index 0 jtag pair, 1 usb pair
	input  wire logic [1:0]                swdClk,
	input  wire logic [1:0]                swdIoIn,
	output var  logic [1:0]                swdIoOut,
	output var  logic [1:0]                swdIoOe_n,
	// port control
	input  wire logic                      jtagCfgDisable,
	input  wire logic                      jtagEnSet,
	input  wire logic                      jtagEnClr,
	input  wire logic                      swdEnSet,
	input  wire logic                      swdEnClr,
	input  wire logic                      scanReq,
	input  wire logic [NUM_PC_BKPT+NUM_LIT_BKPT-1:0] bkptReq,
	output var  logic [1:0]                swdActive,
	output var  logic                      jtagActive,
	output var  logic                      scanGrant,
	output var  logic [NUM_PC_BKPT+NUM_LIT_BKPT-1:0] bkptEn,
	// trace
	input  wire dbg_lock_pkg::trace_t      traceReq,
	output var  logic                      singleTraceEn,
	output var  logic                      parallelTraceEn,
	// flash permission
	input  wire logic [1:0]                protLevel,
	input  wire logic                      fullErase,
	input  wire logic                      protClrReq,
	input  wire logic                      blockOpReq,
	input  wire logic [2:0]                blockOp,
	input  wire logic [2:0]                blockAllow,
	output var  logic                      protClrGrant,
	output var  logic                      blockOpGrant,
	// lock latch
	input  wire logic                      keyLoad,
	input  wire logic [31:0]               keyData,
	input  wire logic                      keyCommit,
	input  wire logic [31:0]               nvReadWord,
	output var  logic                      nvWriteEn,
	output var  logic [31:0]               nvWriteData,
	output var  logic                      lockLive,
	output var  logic                      lockedAtReset
);
	import dbg_lock_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	function automatic logic keyMatch(input logic [31:0] w);
		int n;
		n = 0;
		for (int i = 0; i < KEY_W; i++) begin
			n = n + int'(w[i] == LOCK_KEY[i]);
		end
		return n >= KEY_MATCH_MIN;
	endfunction

	// ------------------------------------------------------------
	// crossings into clk
	// ------------------------------------------------------------
	logic [1:0]  hitTgl;
	logic [1:0]  linkReq;
	logic [1:0]  tgl1_reg, tgl2_reg, tgl3_reg;
	logic [1:0]  req1_reg, req2_reg;
	always_ff @(posedge clk) begin
		tgl1_reg <= hitTgl;
		tgl2_reg <= tgl1_reg;
		tgl3_reg <= tgl2_reg;
		req1_reg <= linkReq;
		req2_reg <= req1_reg;
	end
	logic [1:0] acqEv;
	assign acqEv = tgl2_reg ^ tgl3_reg;

	// ------------------------------------------------------------
	// control state
	// ------------------------------------------------------------
	logic [WIN_CNT_W-1:0] winCnt_reg, winCnt_next;
	logic                 winOpen_reg, winOpen_next;
	logic [1:0]           swd_reg, swd_next;
	logic                 jtag_reg, jtag_next;
	logic                 lockRst_reg, lockRst_next;
	logic                 lockLive_reg, lockLive_next;
	logic [31:0]          stage_reg, stage_next;
	logic                 nvWe_reg, nvWe_next;
	logic [31:0]          nvData_reg, nvData_next;
	logic [1:0]           ack_reg, ack_next;
	logic [31:0]          hold_reg, hold_next;
	logic                 scan_reg, scan_next;
	logic                 sTr_reg, sTr_next;
	logic                 pTr_reg, pTr_next;
	logic                 pClr_reg, pClr_next;
	logic                 bOp_reg, bOp_next;
	logic [NUM_PC_BKPT+NUM_LIT_BKPT-1:0] bkpt_reg, bkpt_next;
	logic                 ext;
	logic                 keyOk;

	always_comb begin
		ext   = (jtag_reg || swd_reg != 2'h0) && !lockRst_reg;
		keyOk = ext && protLevel == PROT_NONE && !lockLive_reg;
		winCnt_next  = winCnt_reg;
		winOpen_next = winOpen_reg;
		swd_next     = swd_reg;
		jtag_next    = jtag_reg;
		lockRst_next = lockRst_reg;
		stage_next   = stage_reg;
		nvData_next  = nvData_reg;
		if (winOpen_reg) begin
			winCnt_next = winCnt_reg + 1'b1;
			if (winCnt_reg == WIN_CNT_W'(KEY_WIN_CYC - 1))
				winOpen_next = 1'b0;
		end
		// pair grant; window closing leaves pins alone
		if (winOpen_reg && swd_reg == 2'h0) begin
			if (acqEv[PAIR_JTAG]) begin
				swd_next  = 2'b01;
				jtag_next = 1'b0;
			end else if (acqEv[PAIR_USB])
				swd_next = 2'b10;
		end
		if (jtag_reg && swdEnSet) begin
			swd_next  = 2'b01;
			jtag_next = 1'b0;
		end
		if (swdEnClr)
			swd_next = 2'h0;
		if (jtagEnSet && swd_reg != 2'h0) begin
			jtag_next = 1'b1;
			swd_next  = swd_reg & 2'b10;
		end
		if (jtagEnClr)
			jtag_next = 1'b0;
		if (keyLoad && keyOk)
			stage_next = keyData;
		nvWe_next = keyCommit && keyOk;
		if (nvWe_next)
			nvData_next = stage_reg;
		lockLive_next = keyMatch(nvReadWord);
		// read snapshot frozen while any link asks
		ack_next  = req2_reg;
		hold_next = (req2_reg == 2'h0 && ack_reg == 2'h0) ?
			nvReadWord : hold_reg;
		scan_next = scanReq && jtag_reg && ext;
		bkpt_next = ext ? bkptReq : '0;
		sTr_next  = traceReq == TR_SINGLE && swd_reg != 2'h0 &&
			!jtag_reg && ext;
		pTr_next  = traceReq == TR_PARALLEL && ext;
		pClr_next = protClrReq && fullErase && ext;
		bOp_next  = blockOpReq && ext && blockOp != 3'h0 &&
			(blockOp & ~blockAllow) == 3'h0;
		if (rst) begin
			winCnt_next  = '0;
			winOpen_next = 1'b1;
			swd_next     = 2'h0;
			lockRst_next = lockLive_next;
			jtag_next    = JTAG_DEFAULT && !jtagCfgDisable &&
				!lockLive_next;
			stage_next   = '0;
			nvWe_next    = 1'b0;
			nvData_next  = '0;
			ack_next     = 2'h0;
			scan_next    = 1'b0;
			bkpt_next    = '0;
			sTr_next     = 1'b0;
			pTr_next     = 1'b0;
			pClr_next    = 1'b0;
			bOp_next     = 1'b0;
		end
		if (lockRst_reg && !rst) begin
			swd_next  = 2'h0;
			jtag_next = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		winCnt_reg   <= winCnt_next;
		winOpen_reg  <= winOpen_next;
		swd_reg      <= swd_next;
		jtag_reg     <= jtag_next;
		lockRst_reg  <= lockRst_next;
		lockLive_reg <= lockLive_next;
		stage_reg    <= stage_next;
		nvWe_reg     <= nvWe_next;
		nvData_reg   <= nvData_next;
		ack_reg      <= ack_next;
		hold_reg     <= hold_next;
		scan_reg     <= scan_next;
		bkpt_reg     <= bkpt_next;
		sTr_reg      <= sTr_next;
		pTr_reg      <= pTr_next;
		pClr_reg     <= pClr_next;
		bOp_reg      <= bOp_next;
	end

	assign swdActive       = swd_reg;
	assign jtagActive      = jtag_reg;
	assign scanGrant       = scan_reg;
	assign bkptEn          = bkpt_reg;
	assign singleTraceEn   = sTr_reg;
	assign parallelTraceEn = pTr_reg;
	assign protClrGrant    = pClr_reg;
	assign blockOpGrant    = bOp_reg;
	assign nvWriteEn       = nvWe_reg;
	assign nvWriteData     = nvData_reg;
	assign lockLive        = lockLive_reg;
	assign lockedAtReset   = lockRst_reg;

	// ------------------------------------------------------------
	// link side, one per pin pair
	// ------------------------------------------------------------
	for (genvar g = 0; g < 2; g++) begin : gLink
		logic        r1_reg, r2_reg, w1_reg, w2_reg;
		logic        a1_reg, a2_reg, k1_reg, k2_reg;
		logic [15:0] sh_reg, sh_next;
		logic [5:0]  cnt_reg, cnt_next;
		logic [31:0] word_reg, word_next;
		logic        tg_reg, tg_next;
		logic        rq_reg, rq_next;
		logic        out_reg, out_next;
		logic        oe_reg, oe_next;
		link_state_t st_reg, st_next;

		always_ff @(posedge swdClk[g]) begin
			r1_reg <= rst;
			r2_reg <= r1_reg;
			w1_reg <= winOpen_reg;
			w2_reg <= w1_reg;
			a1_reg <= swd_reg[g];
			a2_reg <= a1_reg;
			k1_reg <= ack_reg[g];
			k2_reg <= k1_reg;
		end

		always_comb begin
			sh_next   = {sh_reg[14:0], swdIoIn[g]};
			cnt_next  = cnt_reg;
			word_next = word_reg;
			tg_next   = tg_reg;
			rq_next   = rq_reg;
			out_next  = 1'b0;
			oe_next   = 1'b1;
			st_next   = st_reg;
			case (st_reg)
				L_HUNT: begin
					if (w2_reg && sh_next == ACQ_PATTERN) begin
						tg_next = !tg_reg;
						sh_next = '0;
					end
					if (a2_reg)
						st_next = L_CMD;
				end
				L_CMD: begin
					if (sh_next[CMD_W-1:0] == CMD_READ_LOCK && !k2_reg) begin
						rq_next = 1'b1;
						st_next = L_REQ;
					end
				end
				L_REQ: begin
					if (k2_reg) begin
						word_next = hold_reg;
						cnt_next  = '0;
						st_next   = L_SEND;
					end
				end
				L_SEND: begin
					out_next  = word_reg[0];
					oe_next   = 1'b0;
					word_next = {1'b0, word_reg[31:1]};
					cnt_next  = cnt_reg + 1'b1;
					if (cnt_reg == LAST_BIT) begin
						rq_next = 1'b0;
						st_next = L_CMD;
					end
				end
				default: st_next = L_HUNT;
			endcase
			if (!a2_reg && st_reg != L_HUNT) begin
				st_next = L_HUNT;
				rq_next = 1'b0;
				oe_next = 1'b1;
			end
			if (r2_reg) begin
				sh_next = '0;
				// toggle back to idle; edge lands inside reset
				tg_next = 1'b0;
				rq_next = 1'b0;
				oe_next = 1'b1;
				st_next = L_HUNT;
			end
		end

		always_ff @(posedge swdClk[g]) begin
			sh_reg   <= sh_next;
			cnt_reg  <= cnt_next;
			word_reg <= word_next;
			tg_reg   <= tg_next;
			rq_reg   <= rq_next;
			out_reg  <= out_next;
			oe_reg   <= oe_next;
			st_reg   <= st_next;
		end

		assign hitTgl[g]    = tg_reg;
		assign linkReq[g]   = rq_reg;
		assign swdIoOut[g]  = out_reg;
		assign swdIoOe_n[g] = oe_reg;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_one_pair: assert property (swd_reg != 2'b11)
		else $error("wire debug on both pairs");
	a_acq_window: assert property (
		swd_reg == 2'h0 && !(jtag_reg && swdEnSet)
		|=> swd_reg == 2'h0 || $past(winOpen_reg))
		else $error("pair granted outside key window");
	a_window_len: assert property ($fell(winOpen_reg)
		|-> $past(winCnt_reg) == WIN_CNT_W'(KEY_WIN_CYC - 1))
		else $error("key window length wrong");
	a_lock_block: assert property (lockRst_reg ##1 lockRst_reg
		|-> !jtag_reg && swd_reg == 2'h0 && !pClr_reg)
		else $error("access while locked");
	a_lock_sample: assert property ($past(!rst)
		|-> $stable(lockRst_reg))
		else $error("lock sample changed outside reset");
	a_key_prot: assert property (nvWe_reg
		|-> $past(protLevel == PROT_NONE && !lockLive_reg && ext))
		else $error("key write with protection set");
	a_latch_frozen: assert property (lockLive_reg |=> !nvWe_reg)
		else $error("latch altered while locked");
	a_trace_pair: assert property (sTr_reg
		|-> $past(!jtag_reg && swd_reg != 2'h0))
		else $error("single trace with jtag");
	a_prot_clear: assert property (pClr_reg |-> $past(fullErase))
		else $error("protection cleared without erase");
	a_block_op: assert property (bOp_reg
		|-> $past((blockOp & ~blockAllow) == 3'h0))
		else $error("block op not allowed");

	c_acq_jtag: cover property (!swd_reg[0] ##1 swd_reg[0]);
	c_acq_usb: cover property (!swd_reg[1] ##1 swd_reg[1]);
	c_key_commit: cover property (nvWe_reg);
	c_lock_read: cover property (ack_reg != 2'h0);
endmodule
`default_nettype wire

// ==== common/dbg_lock_pkg.sv ====
/*
 * constants and types for debug port selection and device lock.
 * assumes a 100 mhz system clock; host-driven wire clocks.
 */
`default_nettype none
package dbg_lock_pkg;
	// ------------------------------------------------------------
	// lock latch
	// ------------------------------------------------------------
	localparam int          KEY_W         = 32;
	localparam int          KEY_MATCH_MIN = 28;
	// value arbitrary
	localparam logic [31:0] LOCK_KEY      = 32'h3c5a_e196;
	localparam logic [1:0]  PROT_NONE     = 2'h0;
	// ------------------------------------------------------------
	// key window timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 10000;
	localparam int KEY_WIN_US    = 8;
	localparam int KEY_WIN_CYC   = KEY_WIN_US * 1000000 / CLK_PERIOD_PS;
	localparam int WIN_CNT_W     = 10;
	// ------------------------------------------------------------
	// wire protocol patterns
	// ------------------------------------------------------------
	localparam int          ACQ_W         = 16;
	localparam logic [15:0] ACQ_PATTERN   = 16'h9e6b;
	localparam int          CMD_W         = 8;
	localparam logic [7:0]  CMD_READ_LOCK = 8'ha5;
	localparam logic [5:0]  LAST_BIT      = 6'h1f;
	// pair index: 0 = jtag mode/clock pins, 1 = usb d+/d- pins
	localparam int          PAIR_JTAG     = 0;
	localparam int          PAIR_USB      = 1;
	localparam logic        JTAG_DEFAULT  = 1'b1;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		TR_NONE     = 2'h0,
		TR_SINGLE   = 2'h1,
		TR_PARALLEL = 2'h2
	} trace_t;
	typedef enum logic [3:0] {
		L_HUNT = 4'b0001,
		L_CMD  = 4'b0010,
		L_REQ  = 4'b0100,
		L_SEND = 4'b1000
	} link_state_t;
endpackage
`default_nettype wire

// ==== testbench/swd_host_model.sv ====
/*
 * host model for both wire debug pairs: makes the wire clocks and data.
 * assumes the device samples data on the rising wire clock.
 */
`default_nettype none
module swd_host_model (
	// wire pins
	output var  logic [1:0] swdClk,
	output var  logic [1:0] swdIoIn,
	input  wire logic [1:0] swdIoOut,
	input  wire logic [1:0] swdIoOe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	// 48 ns period, below a third of the cpu clock
	localparam real HALF = 24.0;
	logic [1:0] hostDrive = 2'b00;
	logic [1:0] hostVal = 2'b00;
	// released line shows the inverse of the last driven level
	assign swdIoIn = (~swdIoOe_n & swdIoOut)
		| (swdIoOe_n & ~(hostDrive ^ hostVal));
	initial swdClk = 2'b00;
	// clock the masked pairs with data released
	task automatic idle(input logic [1:0] mask, input int n);
		hostDrive = 2'b00;
		repeat (n) begin
			#HALF swdClk = mask;
			#HALF swdClk = 2'b00;
		end
	endtask
	// drive n bits msb first; data stays driven, clock stands still
	task automatic send(input int g, input logic [15:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			hostDrive[g] = 1'b1;
			hostVal[g] = v[i];
			#HALF swdClk[g] = 1'b1;
			#HALF swdClk[g] = 1'b0;
		end
	endtask
	// clock until the device has driven 32 bits or 80 clocks pass, lsb first
	task automatic read(input int g, output logic [31:0] w, output int got);
		hostDrive[g] = 1'b0;
		got = 0;
		w = 32'h0;
		for (int e = 0; e < 80 && got < 32; e++) begin
			#HALF swdClk[g] = 1'b1;
			#HALF if (swdIoOe_n[g] === 1'b0) begin
				w[got] = swdIoIn[g];
				got++;
			end
			swdClk[g] = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ==== testbench/debug_port_lock_tb.sv ====
/*
 * bench for debug port selection, flash permission and lock latch.
 * assumes the host model and a cell array model kept here.
 */
`default_nettype none
module debug_port_lock_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import dbg_lock_pkg::*;
	`define CHK(nm, ex, gt) begin \
		compares++; \
		if ((gt) !== (ex)) begin \
			errCount++; \
			$display("Error %s expected %h seen %h", nm, ex, gt); \
		end \
	end
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        clk = 1'b0, rst = 1'b1, jtagCfgDisable = 1'b0;
	logic        jtagEnSet = 1'b0, jtagEnClr = 1'b0, scanReq = 1'b0;
	logic        swdEnSet = 1'b0, swdEnClr = 1'b0, fullErase = 1'b0;
	logic        protClrReq = 1'b0, blockOpReq = 1'b0;
	logic        keyLoad = 1'b0, keyCommit = 1'b0;
	logic [1:0]  protLevel = 2'h0, swdClk, swdIoIn, swdIoOut, swdIoOe_n;
	logic [2:0]  blockOp = 3'h0, blockAllow = 3'h3;
	logic [7:0]  bkptReq = 8'h00, bkptEn;
	logic [31:0] keyData = 32'h0, cells = 32'h0, rdWord, nvWriteData;
	trace_t      traceReq = TR_NONE;
	logic [1:0]  swdActive;
	logic        jtagActive, scanGrant, singleTraceEn, parallelTraceEn;
	logic        protClrGrant, blockOpGrant, nvWriteEn, lockLive;
	logic        lockedAtReset;
	int          errCount = 0, compares = 0, cycles = 0, nvWrites = 0;
	int          got;
	always #5 clk = ~clk;
	debug_port_lock dut (.clk, .rst, .swdClk, .swdIoIn, .swdIoOut,
		.swdIoOe_n, .jtagCfgDisable, .jtagEnSet, .jtagEnClr, .swdEnSet,
		.swdEnClr, .scanReq, .bkptReq, .swdActive, .jtagActive, .scanGrant,
		.bkptEn, .traceReq, .singleTraceEn, .parallelTraceEn, .protLevel,
		.fullErase, .protClrReq, .blockOpReq, .blockOp, .blockAllow,
		.protClrGrant, .blockOpGrant, .keyLoad, .keyData, .keyCommit,
		.nvReadWord(cells), .nvWriteEn, .nvWriteData, .lockLive,
		.lockedAtReset);
	swd_host_model host (.swdClk, .swdIoIn, .swdIoOut, .swdIoOe_n);
	// cell array takes a commit at the clock edge; hang limit
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (nvWriteEn === 1'b1) begin
			cells <= nvWriteData;
			nvWrites <= nvWrites + 1;
		end
		if (cycles == 20000) begin
			errCount++;
			final_report();
		end
	end
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, errCount);
		if (errCount == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic do_reset(input logic [31:0] c, input logic cfgOff);
		@(negedge clk);
		rst = 1'b1;
		cells = c;
		jtagCfgDisable = cfgOff;
		fork
			host.idle(2'b11, 4);
			tick(16);
		join
		tick(1);
		rst = 1'b0;
		tick(2);
	endtask
	task automatic acquire(input int g);
		host.send(g, 16'h0, 4);
		host.send(g, ACQ_PATTERN, ACQ_W);
		host.send(g, 16'h0, 2);
		tick(8);
	endtask
	task automatic write_key(input logic [31:0] k);
		keyData = k;
		keyLoad = 1'b1;
		tick(1);
		keyLoad = 1'b0;
		keyCommit = 1'b1;
		tick(1);
		keyCommit = 1'b0;
		tick(3);
	endtask
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		do_reset(32'h0, 1'b0);
		`CHK("jtagActive", 1'b1, jtagActive)
		`CHK("lockedAtReset", 1'b0, lockedAtReset)
		`CHK("swdActive", 2'b00, swdActive)
		traceReq = TR_SINGLE;
		scanReq = 1'b1;
		tick(2);
		`CHK("singleTraceEn", 1'b0, singleTraceEn)
		`CHK("scanGrant", 1'b1, scanGrant)
		traceReq = TR_PARALLEL;
		tick(2);
		`CHK("parallelTraceEn", 1'b1, parallelTraceEn)
		acquire(1);
		`CHK("swdActive", 2'b10, swdActive)
		acquire(0);
		`CHK("swdActive", 2'b10, swdActive)
		traceReq = TR_SINGLE;
		bkptReq = 8'hff;
		cells = 32'h1234_abcd;
		tick(2);
		// jtag still on, so single trace stays refused
		`CHK("singleTraceEn", 1'b0, singleTraceEn)
		`CHK("bkptEn", 8'hff, bkptEn)
		host.send(1, 16'h0, 4);
		host.send(1, {8'h00, CMD_READ_LOCK}, CMD_W);
		host.read(1, rdWord, got);
		tick(1);
		`CHK("rdWord", 32'h1234_abcd, rdWord)
		`CHK("got", 32, got)
		protLevel = 2'h1;
		protClrReq = 1'b1;
		tick(2);
		`CHK("protClrGrant", 1'b0, protClrGrant)
		fullErase = 1'b1;
		tick(2);
		`CHK("protClrGrant", 1'b1, protClrGrant)
		blockOpReq = 1'b1;
		for (int i = 0; i < 3; i++) begin
			blockOp = 3'h1 << i;
			tick(2);
			`CHK("blockOpGrant", blockAllow[i], blockOpGrant)
		end
		write_key(LOCK_KEY);
		`CHK("nvWrites", 0, nvWrites)
		protLevel = PROT_NONE;
		write_key(LOCK_KEY);
		`CHK("nvWrites", 1, nvWrites)
		`CHK("cells", LOCK_KEY, cells)
		`CHK("lockLive", 1'b1, lockLive)
		`CHK("jtagActive", 1'b1, jtagActive)
		`CHK("swdActive", 2'b10, swdActive)
		`CHK("lockedAtReset", 1'b0, lockedAtReset)
		cells = LOCK_KEY ^ 32'h0000_001f;
		tick(2);
		`CHK("lockLive", 1'b0, lockLive)
		$display("test unlocked done");
		do_reset(LOCK_KEY ^ 32'h8000_0007, 1'b0);
		`CHK("lockedAtReset", 1'b1, lockedAtReset)
		`CHK("jtagActive", 1'b0, jtagActive)
		acquire(1);
		`CHK("swdActive", 2'b00, swdActive)
		`CHK("bkptEn", 8'h00, bkptEn)
		`CHK("scanGrant", 1'b0, scanGrant)
		write_key(32'h0);
		`CHK("nvWrites", 1, nvWrites)
		$display("test locked done");
		do_reset(32'h0, 1'b1);
		`CHK("jtagActive", 1'b0, jtagActive)
		acquire(1);
		`CHK("swdActive", 2'b10, swdActive)
		jtagEnSet = 1'b1;
		tick(1);
		jtagEnSet = 1'b0;
		tick(2);
		`CHK("jtagActive", 1'b1, jtagActive)
		swdEnClr = 1'b1;
		tick(1);
		swdEnClr = 1'b0;
		tick(800);
		`CHK("swdActive", 2'b00, swdActive)
		acquire(0);
		`CHK("swdActive", 2'b00, swdActive)
		swdEnSet = 1'b1;
		tick(1);
		swdEnSet = 1'b0;
		tick(2);
		`CHK("swdActive", 2'b01, swdActive)
		`CHK("scanGrant", 1'b0, scanGrant)
		`CHK("singleTraceEn", 1'b1, singleTraceEn)
		$display("test reacquire done");
		final_report();
	end
endmodule
`default_nettype wire
